//--- spwf_params.svh
`ifndef SPWF_PARAMS_SVH
`define SPWF_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SPWF_OFF_CTRL 12'h000
`define SPWF_OFF_SAFE 12'h004
`define SPWF_OFF_CMD 12'h008
`define SPWF_OFF_TARGET 12'h00c
`define SPWF_OFF_ACTUAL 12'h010
`define SPWF_OFF_STATUS 12'h014
`define SPWF_OFF_CURRENT 12'h018
`define SPWF_OFF_OTP 12'h01c
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SPWF_CTRL_MODE_LSB 0
`define SPWF_CTRL_SHAFT 2
`define SPWF_CTRL_FALLBACK 3
`define SPWF_CTRL_SLEEP 4
// ----------------------------------------------------------------
// Command register codes (written with the position word in bits 31:16)
// ----------------------------------------------------------------
`define SPWF_CMD_MOVE 4'h1
`define SPWF_CMD_SHORT 4'h2
`define SPWF_CMD_GO_SAFE 4'h3
`define SPWF_CMD_REFERENCE 4'h4
`define SPWF_CMD_LOST_LINK 4'h5
`define SPWF_CMD_STOP 4'h6
// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define SPWF_SAFE_DISABLED 11'h400
`define SPWF_CTRL_RESET 5'h00
`define SPWF_CURRENT_RESET 16'h0000
`define SPWF_STEP_TIME_NS 1000
`define SPWF_CLK_NS 50
`define SPWF_STEP_CYCLES ((`SPWF_STEP_TIME_NS + `SPWF_CLK_NS - 1) / `SPWF_CLK_NS)
`endif

//--- spwf_pkg.sv
package spwf_pkg;
  // Stepping mode selector
  typedef enum logic [1:0] {
    SPWF_HALF = 2'h0,
    SPWF_QUARTER = 2'h1,
    SPWF_EIGHTH = 2'h2,
    SPWF_SIXTEENTH = 2'h3
  } spwf_mode_t;
  // Motion state
  typedef enum logic [1:0] {
    SPWF_IDLE,
    SPWF_RUN
  } spwf_state_t;
endpackage : spwf_pkg

//--- spwf_fmt_if.sv
// Carries raw words to the formatter and aligned words back
interface spwf_fmt_if;
  logic [1:0] mode;
  logic [15:0] move_raw;
  logic [15:0] short_raw;
  logic [10:0] safe_raw;
  logic [15:0] move_word;
  logic [15:0] short_word;
  logic [15:0] safe_word;
  logic move_in_range;
  modport ctrl (output mode, output move_raw, output short_raw, output safe_raw,
    input move_word, input short_word, input safe_word, input move_in_range);
  modport fmt (input mode, input move_raw, input short_raw, input safe_raw,
    output move_word, output short_word, output safe_word, output move_in_range);
endinterface : spwf_fmt_if

//--- spwf_align.sv
module spwf_align (
  // Formatter side
  spwf_fmt_if.fmt f
);
  // ----------------------------------------------------------------
  // Word alignment
  // ----------------------------------------------------------------
  wire [1:0] shift_amt;
  wire [15:0] shifted;
  wire [15:0] sign_lim;
  wire [15:0] lim_hi;

  // Half shifts by 3, sixteenth by 0
  assign shift_amt = 2'h3 - f.mode;
  // Sign kept in bit 15, zeros enter below
  assign shifted = {f.move_raw[15], 15'(f.move_raw[14:0] << shift_amt)};
  assign f.move_word = shifted;
  // Bits above the mode's width must be sign copies, else the move is rejected
  assign lim_hi = 16'hffff << (5'd12 + {3'h0, f.mode});
  assign sign_lim = f.move_raw[15] ? lim_hi : 16'h0000;
  assign f.move_in_range = ((f.move_raw & lim_hi) == sign_lim);
  // Short format: sign in 15..13, value 12..3
  assign f.short_word = {{3{f.short_raw[10]}}, f.short_raw[9:0], 3'h0};
  // Safe target: sign 15, value 14..5, one code equals two full steps
  assign f.safe_word = {f.safe_raw[10], f.safe_raw[9:0], 5'h00};
endmodule : spwf_align

//--- spwf_top.sv
`include "spwf_params.svh"
module spwf_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // One-time memory image, valid from reset
  input wire logic [10:0] otp_safe,
  input wire logic otp_shaft,
  // Motor feedback
  input wire logic bemf_low,
  // Motor drive
  output logic step_pulse,
  output logic step_dir,
  output logic coil_x_plus,
  output logic coil_x_minus,
  output logic [3:0] prescale_x,
  output logic [3:0] prescale_y,
  output logic [3:0] ratio_x,
  output logic [3:0] ratio_y
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [4:0] ctrl_r;
  logic [10:0] safe_target_r;
  logic [15:0] current_r;
  logic [15:0] target_r;
  logic [15:0] actual_r;
  logic boot_r;
  logic stall_r;
  logic bad_target_r;
  logic [5:0] step_cnt_r;
  spwf_pkg::spwf_state_t state_r;
  logic [31:0] prdata_r;

  spwf_fmt_if fi ();
  spwf_align u_align (
    .f(fi)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_en;
  wire rd_en;
  wire hit;
  wire cmd_wr;
  wire [3:0] cmd_code;
  wire [15:0] cmd_data;
  wire safe_disabled;
  wire [15:0] move_dist;
  wire at_target;
  wire new_target;
  wire [15:0] new_target_word;
  wire go_safe_ok;
  wire ref_ok;
  wire lost_ok;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign hit = (paddr == `SPWF_OFF_CTRL) | (paddr == `SPWF_OFF_SAFE) |
    (paddr == `SPWF_OFF_CMD) | (paddr == `SPWF_OFF_TARGET) |
    (paddr == `SPWF_OFF_ACTUAL) | (paddr == `SPWF_OFF_STATUS) |
    (paddr == `SPWF_OFF_CURRENT) | (paddr == `SPWF_OFF_OTP);
  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_r;
  assign cmd_wr = wr_en & (paddr == `SPWF_OFF_CMD);
  assign cmd_code = pwdata[3:0];
  assign cmd_data = pwdata[31:16];

  // ----------------------------------------------------------------
  // Formatter hookup
  // ----------------------------------------------------------------
  assign fi.mode = ctrl_r[`SPWF_CTRL_MODE_LSB +: 2];
  assign fi.move_raw = cmd_data;
  assign fi.short_raw = cmd_data[10:0];
  assign fi.safe_raw = safe_target_r;

  // Most negative code disables the safe target for fallback/reference
  assign safe_disabled = (safe_target_r == `SPWF_SAFE_DISABLED);
  assign go_safe_ok = (cmd_code == `SPWF_CMD_GO_SAFE);
  assign ref_ok = (cmd_code == `SPWF_CMD_REFERENCE) & ~safe_disabled;
  assign lost_ok = (cmd_code == `SPWF_CMD_LOST_LINK) & ctrl_r[`SPWF_CTRL_FALLBACK] &
    ~safe_disabled;
  // Latest accepted target always replaces the previous one
  assign new_target = cmd_wr & (((cmd_code == `SPWF_CMD_MOVE) & fi.move_in_range) |
    (cmd_code == `SPWF_CMD_SHORT) | go_safe_ok | ref_ok | lost_ok);
  assign new_target_word = (cmd_code == `SPWF_CMD_MOVE) ? fi.move_word :
    (cmd_code == `SPWF_CMD_SHORT) ? fi.short_word : fi.safe_word;

  // Signed difference; wrap gives shortest way round the circle
  assign move_dist = target_r - actual_r;
  assign at_target = (move_dist == 16'h0000);

  // ----------------------------------------------------------------
  // Configuration and one-time memory copy
  // ----------------------------------------------------------------
  // Boot copy happens one clock after reset release so no port reaches async reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_r <= 1'b1;
      ctrl_r <= `SPWF_CTRL_RESET;
      safe_target_r <= `SPWF_SAFE_DISABLED;
      current_r <= `SPWF_CURRENT_RESET;
    end else if (boot_r) begin
      boot_r <= 1'b0;
      safe_target_r <= {otp_safe[10:2], 2'h0};
      ctrl_r[`SPWF_CTRL_FALLBACK] <= otp_safe[1];
      ctrl_r[`SPWF_CTRL_SLEEP] <= otp_safe[0];
      ctrl_r[`SPWF_CTRL_SHAFT] <= otp_shaft;
    end else if (wr_en) begin
      if (paddr == `SPWF_OFF_CTRL) begin
        ctrl_r <= pwdata[4:0];
      end
      if (paddr == `SPWF_OFF_SAFE) begin
        safe_target_r <= pwdata[10:0];
      end
      if (paddr == `SPWF_OFF_CURRENT) begin
        current_r <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Target and motion
  // ----------------------------------------------------------------
  // Step generator: one step every SPWF_STEP_CYCLES toward the target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_r <= 16'h0000;
      bad_target_r <= 1'b0;
    end else if (cmd_wr) begin
      if (new_target) begin
        target_r <= new_target_word;
      end
      bad_target_r <= (cmd_code == `SPWF_CMD_MOVE) & ~fi.move_in_range;
    end else if (state_r == spwf_pkg::SPWF_RUN && bemf_low) begin
      target_r <= actual_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= spwf_pkg::SPWF_IDLE;
      actual_r <= 16'h0000;
      step_cnt_r <= 6'h00;
      step_pulse <= 1'b0;
      step_dir <= 1'b0;
      stall_r <= 1'b0;
    end else begin
      step_pulse <= 1'b0;
      unique case (state_r)
        spwf_pkg::SPWF_IDLE: begin
          step_cnt_r <= 6'h00;
          if (!at_target && !cmd_wr) begin
            state_r <= spwf_pkg::SPWF_RUN;
            stall_r <= 1'b0;
          end
        end
        spwf_pkg::SPWF_RUN: begin
          if (bemf_low) begin
            state_r <= spwf_pkg::SPWF_IDLE;
            stall_r <= 1'b1;
          end else if (at_target) begin
            state_r <= spwf_pkg::SPWF_IDLE;
          end else if (step_cnt_r == 6'(`SPWF_STEP_CYCLES - 1)) begin
            step_cnt_r <= 6'h00;
            step_pulse <= 1'b1;
            step_dir <= move_dist[15];
            actual_r <= move_dist[15] ? actual_r - 16'h0001 : actual_r + 16'h0001;
          end else begin
            step_cnt_r <= step_cnt_r + 6'h01;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Coil polarity and current settings
  // ----------------------------------------------------------------
  // Shaft swaps which X pin is positive; high marks the pin driven as positive
  assign coil_x_plus = ~ctrl_r[`SPWF_CTRL_SHAFT];
  assign coil_x_minus = ctrl_r[`SPWF_CTRL_SHAFT];
  assign prescale_x = current_r[3:0];
  assign prescale_y = current_r[7:4];
  assign ratio_x = current_r[11:8];
  assign ratio_y = current_r[15:12];

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        `SPWF_OFF_CTRL: prdata_r <= {27'h0, ctrl_r};
        `SPWF_OFF_SAFE: prdata_r <= {21'h0, safe_target_r};
        `SPWF_OFF_TARGET: prdata_r <= {16'h0, target_r};
        `SPWF_OFF_ACTUAL: prdata_r <= {16'h0, actual_r};
        `SPWF_OFF_STATUS: prdata_r <= {28'h0, bad_target_r, safe_disabled, stall_r,
          state_r == spwf_pkg::SPWF_RUN};
        `SPWF_OFF_CURRENT: prdata_r <= {16'h0, current_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end
endmodule : spwf_top

//--- spwf_sva.sv
`include "spwf_params.svh"
// Watches bus answers and motor outputs of spwf_top
module spwf_sva (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Motor
  input wire logic bemf_low,
  input wire logic step_pulse,
  input wire logic coil_x_plus,
  input wire logic coil_x_minus,
  input wire logic [3:0] prescale_x,
  input wire logic [3:0] ratio_y
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Access decode; anything past the last word is unmapped
  wire acc = psel & penable;
  wire bad = acc & (paddr > `SPWF_OFF_OTP);
  wire wr_ctrl = acc & pwrite & (paddr == `SPWF_OFF_CTRL);
  wire wr_cur = acc & pwrite & (paddr == `SPWF_OFF_CURRENT);
  wire shaft_w = pwdata[`SPWF_CTRL_SHAFT];
  wire [7:0] cur_w = {pwdata[15:12], pwdata[3:0]};
  wire [7:0] cur_o = {ratio_y, prescale_x};
  a_no_wait: assert property (acc |-> pready) else $error("wait state");
  a_bad_err: assert property (bad |-> pslverr) else $error("no error");
  a_bad_zero: assert property (bad && !pwrite |-> prdata == 32'h0) else $error("data");
  a_coil_pair: assert property (coil_x_minus == !coil_x_plus) else $error("coil");
  a_shaft_load: assert property (wr_ctrl |=> coil_x_plus == !$past(shaft_w)) else $error("shaft");
  a_cur_map: assert property (wr_cur |=> cur_o == $past(cur_w)) else $error("current");
  a_stall_stop: assert property (bemf_low |-> ##2 !step_pulse [*4]) else $error("stall");
  a_step_gap: assert property (step_pulse |=> !step_pulse [*8]) else $error("step gap");
  // Main scenarios
  c_stall: cover property (bemf_low ##1 !bemf_low);
  c_bad: cover property (bad);
  c_cur: cover property (wr_cur);
endmodule : spwf_sva
bind spwf_top spwf_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .bemf_low(bemf_low), .step_pulse(step_pulse), .coil_x_plus(coil_x_plus),
  .coil_x_minus(coil_x_minus), .prescale_x(prescale_x), .ratio_y(ratio_y));

//--- spwf_apb_master.sv
// Command source on the register bus
module spwf_apb_master (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  // One transfer; data inverted on release so stale values never look valid
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e, output bit ok);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    ok = 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge pclk);
      ok = (pready === 1'b1);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : xfer
endmodule : spwf_apb_master

//--- tb_top.sv
`include "spwf_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, bemf_low = 0, otp_shaft = 1;
  logic [10:0] otp_safe = 11'h5a7;
  logic psel, penable, pwrite, pready, pslverr, step_pulse, step_dir, xp, xn, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] px, py, rx, ry;
  int failures = 0, n_compared = 0;
  // 20 MHz clock
  always #25 pclk = ~pclk;
  spwf_apb_master u_mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  spwf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .otp_safe(otp_safe), .otp_shaft(otp_shaft), .bemf_low(bemf_low),
    .step_pulse(step_pulse), .step_dir(step_dir), .coil_x_plus(xp), .coil_x_minus(xn),
    .prescale_x(px), .prescale_y(py), .ratio_x(rx), .ratio_y(ry));
  task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bus transfer; a hung handshake ends the run
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    bit ok;
    u_mst.xfer(w, a, d, q, e, ok);
    if (!ok) begin
      failures++;
      stop_test();
    end
  endtask : xf
  task cmd(input logic [3:0] c, input logic [15:0] p);
    xf(1, `SPWF_OFF_CMD, {p, 12'h000, c});
  endtask : cmd
  task rdc(input logic [11:0] a, input logic [31:0] x);
    xf(0, a, 0);
    chk(q, x);
  endtask : rdc
  // Start-up copy and shaft from the one-time image
  task t_boot;
    rdc(`SPWF_OFF_SAFE, 32'h5a4);
    chk({xp, xn}, 2'b01);
    $display("boot done");
  endtask : t_boot
  // Largest and most negative target in every mode, then range and short form
  task t_align;
    logic [15:0] r;
    for (int m = 0; m < 4; m++) begin
      r = 16'hffff >> (4 - m);
      xf(1, `SPWF_OFF_CTRL, m);
      cmd(`SPWF_CMD_MOVE, r);
      rdc(`SPWF_OFF_TARGET, 16'(r << (3 - m)));
      cmd(`SPWF_CMD_MOVE, ~r);
      rdc(`SPWF_OFF_TARGET, 32'h8000);
    end
    cmd(`SPWF_CMD_MOVE, 16'h0001);
    cmd(`SPWF_CMD_MOVE, 16'hffff);
    rdc(`SPWF_OFF_TARGET, 32'hffff);
    xf(1, `SPWF_OFF_CTRL, 0);
    cmd(`SPWF_CMD_MOVE, 16'h1000);
    rdc(`SPWF_OFF_TARGET, 32'hffff);
    xf(0, `SPWF_OFF_STATUS, 0);
    chk(q[3], 1);
    cmd(`SPWF_CMD_SHORT, 16'h0601);
    rdc(`SPWF_OFF_TARGET, 32'hf008);
    $display("align done");
  endtask : t_align
  // Safe target mapping and the disable code
  task t_safe;
    xf(1, `SPWF_OFF_SAFE, 32'h2c5);
    cmd(`SPWF_CMD_GO_SAFE, 0);
    rdc(`SPWF_OFF_TARGET, 32'h58a0);
    cmd(`SPWF_CMD_MOVE, 16'h0005);
    cmd(`SPWF_CMD_REFERENCE, 0);
    rdc(`SPWF_OFF_TARGET, 32'h58a0);
    cmd(`SPWF_CMD_MOVE, 16'h0005);
    cmd(`SPWF_CMD_LOST_LINK, 0);
    rdc(`SPWF_OFF_TARGET, 32'h28);
    xf(1, `SPWF_OFF_CTRL, 32'h8);
    chk({xp, xn}, 2'b10);
    cmd(`SPWF_CMD_LOST_LINK, 0);
    rdc(`SPWF_OFF_TARGET, 32'h58a0);
    xf(1, `SPWF_OFF_SAFE, `SPWF_SAFE_DISABLED);
    cmd(`SPWF_CMD_MOVE, 16'h0005);
    cmd(`SPWF_CMD_REFERENCE, 0);
    cmd(`SPWF_CMD_LOST_LINK, 0);
    rdc(`SPWF_OFF_TARGET, 32'h28);
    xf(0, `SPWF_OFF_STATUS, 0);
    chk(q[2], 1);
    cmd(`SPWF_CMD_GO_SAFE, 0);
    rdc(`SPWF_OFF_TARGET, 32'h8000);
    $display("safe done");
  endtask : t_safe
  // Currents, stall while stepping, unmapped access
  task t_motor;
    logic [31:0] s;
    xf(1, `SPWF_OFF_CURRENT, 32'hc3a5);
    chk({ry, rx, py, px}, 16'hc3a5);
    xf(1, `SPWF_OFF_CTRL, 3);
    xf(0, `SPWF_OFF_ACTUAL, 0);
    cmd(`SPWF_CMD_MOVE, q[15:0] + 16'h0100);
    for (int i = 0; i < 100 && step_pulse !== 1'b1; i++) @(posedge pclk);
    chk(step_pulse, 1);
    if (step_pulse !== 1'b1) stop_test();
    chk(step_dir, 0);
    bemf_low <= 1'b1;
    repeat (3) @(posedge pclk);
    bemf_low <= 1'b0;
    xf(0, `SPWF_OFF_STATUS, 0);
    chk(q[1:0], 2'b10);
    xf(0, `SPWF_OFF_ACTUAL, 0);
    s = q;
    repeat (50) @(posedge pclk);
    rdc(`SPWF_OFF_ACTUAL, s);
    xf(1, 12'h040, 1);
    chk(e, 1);
    rdc(12'h040, 0);
    $display("motor done");
  endtask : t_motor
  // Reset held three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_boot();
    t_align();
    t_safe();
    t_motor();
    stop_test();
  end
endmodule : tb_top
